// *** rtl/cabx_cfg.svh ***
// Operation
// [RL1] add registers, optional carry, flags ZCNVH, one cycle
// [RL2] subtract registers, optional carry, ZCNVH, one cycle
// [RL3] subtract constant, optional carry, ZCNVH, one cycle
// [RL4] word add/subtract constant, ZCNVS, two cycles
// [RL5] and/or with constant, flags ZNV, one cycle
// [RL6] clear/set bits by mask, ZNV, one cycle
// [RL7] zero-minus test keeps value, sets ZNV
// [RL8] integer products into pair one:zero, ZC, two cycles
// [RL9] scaled products shifted left once, ZC, two
// [RL10] pointer jump loads pc from Z, two cycles
// [RL11] extended jump uses page register above Z
// [RL12] pointer call saves return, four cycles
// [RL13] extended pointer call, five cycles, flags kept
// [RL14] direct call to absolute address, five cycles
// [RL15] compare-skip-equal skips one or two words
// [RL16] compare immediate updates ZNVCH, stores nothing
// [RL17] register bit skips on cleared or set
// [RL18] io bit skips on cleared or set
// [RL19] flags not affected keep their value
`ifndef CABX_CFG_SVH
`define CABX_CFG_SVH
// status register bit positions
`define CABX_FC 0
`define CABX_FZ 1
`define CABX_FN 2
`define CABX_FV 3
`define CABX_FS 4
`define CABX_FH 5
// register map indices of the plain register port
`define CABX_ADR_SREG 6'h20
`define CABX_ADR_PAGE 6'h21
`define CABX_ADR_PCL  6'h22
`define CABX_ADR_PCM  6'h23
`define CABX_ADR_PCH  6'h24
// fixed register numbers
`define CABX_R_ZLO 5'h1e
`define CABX_R_ZHI 5'h1f
`define CABX_R_PLO 5'h00
`define CABX_R_PHI 5'h01
// cycle counts
`define CABX_N1 3'h1
`define CABX_N2 3'h2
`define CABX_N3 3'h3
`define CABX_N4 3'h4
`define CABX_N5 3'h5
// reset value and all-ones byte mask
`define CABX_SREG_RST 8'h00
`define CABX_BYTE_ALL 8'hff
`endif

// *** rtl/cabx_pkg.sv ***
package cabx_pkg;
  // operations carried out by the execution block
  typedef enum logic [4:0] {
    op_sum, op_sum_carry, op_difference, register_difference_borrow,
    constant_difference, constant_difference_borrow,
    word_immediate_sum, word_immediate_difference,
    bitwise_and_constant, bitwise_or_constant, set_bits_mask, clear_bits_mask,
    zero_minus_test, product_unsigned, product_signed, product_mixed_sign,
    scaled_product_unsigned, scaled_product_signed, scaled_product_mixed,
    pointer_jump, extended_pointer_jump, pointer_call, extended_pointer_call,
    direct_call, compare_skip_equal, compare_immediate,
    skip_reg_bit_low, skip_reg_bit_high, skip_io_bit_low, skip_io_bit_high
  } cabx_op_e;
  // one instruction handed to the block
  typedef struct packed {
    logic        valid;    // instruction present
    cabx_op_e    op;       // operation
    logic [4:0]  d;        // destination / first register
    logic [4:0]  r;        // second register
    logic [7:0]  k;        // immediate constant
    logic [2:0]  bsel;     // bit select for skips
    logic        io_bit;   // sampled io register bit
    logic        next_two; // following instruction is two words
    logic [21:0] target;   // absolute call address
  } cabx_cmd_s;
  // plain register port
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cabx_bus_s;
endpackage : cabx_pkg

// *** rtl/cabx_exec.sv ***
`timescale 1ns/10ps
`include "cabx_cfg.svh"
module cabx_exec #(
  parameter int PC_W = 22
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire cabx_pkg::cabx_cmd_s cmd,
  input  wire cabx_pkg::cabx_bus_s bus,
  output logic [7:0]             rdata,
  output logic                   busy,
  output logic                   done,
  output logic [PC_W-1:0]        pc,
  output logic [7:0]             sreg,
  output logic                   push_valid,
  output logic [PC_W-1:0]        push_addr
);

  // 8-bit add or subtract with carry-in; returns {h, v, c, result}
  function automatic logic [10:0] alu8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci,
                                       input logic sub);
    logic [8:0] s;
    logic [4:0] hs;
    logic v;
    if (sub)
    begin
      s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
      v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
    end
    else
    begin
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
    end
    return {hs[4], v, s[8], s[7:0]};
  endfunction : alu8

  // storage
  logic [7:0]      rf_reg [32];   // general registers
  logic [7:0]      sreg_reg;      // status register
  logic [7:0]      page_reg;      // jump page extension
  logic [PC_W-1:0] pc_reg;        // program counter
  logic [7:0]      rdata_reg;     // read data, one cycle after strobe
  logic            busy_reg;      // multi-cycle instruction running
  logic            done_reg;      // completion pulse
  logic            push_reg;      // return address push pulse
  logic [PC_W-1:0] push_a_reg;    // pushed return address
  logic [2:0]      cnt_reg;       // cycles left

  // held results of a multi-cycle instruction
  logic [4:0]      h_d;
  logic [15:0]     h_res;
  logic [7:0]      h_sreg;
  logic [PC_W-1:0] h_pc;
  logic [1:0]      h_wr;
  logic            h_push;

  // operand fetch
  wire logic             take   = cmd.valid & ~busy_reg;
  wire logic [7:0]       op_a   = rf_reg[cmd.d];
  wire logic [7:0]       op_b   = rf_reg[cmd.r];
  wire logic [4:0]       d_hi   = cmd.d + 5'h01;
  wire logic [15:0]      word_v = {rf_reg[d_hi], op_a};
  wire logic [15:0]      z_ptr  = {rf_reg[`CABX_R_ZHI], rf_reg[`CABX_R_ZLO]};
  wire logic [23:0]      ez_ptr = {page_reg, z_ptr};
  wire logic             c_in   = sreg_reg[`CABX_FC];
  wire logic             z_in   = sreg_reg[`CABX_FZ];
  wire logic [PC_W-1:0]  pc_one = pc_reg + PC_W'(1);
  wire logic [PC_W-1:0]  pc_two = pc_reg + PC_W'(2);
  wire logic [PC_W-1:0]  pc_thr = pc_reg + PC_W'(3);

  // shared arithmetic paths
  wire logic [10:0] add_r = alu8(op_a, op_b, cmd.op == cabx_pkg::op_sum_carry ? c_in : 1'b0,
                                 1'b0);
  wire logic        brw   = (cmd.op == cabx_pkg::register_difference_borrow) |
                            (cmd.op == cabx_pkg::constant_difference_borrow);
  wire logic [7:0]  sub_b = (cmd.op == cabx_pkg::op_difference) |
                            (cmd.op == cabx_pkg::register_difference_borrow) ? op_b : cmd.k;
  wire logic [10:0] sub_r = alu8(op_a, sub_b, brw ? c_in : 1'b0, 1'b1);

  // word arithmetic
  wire logic        w_sub = cmd.op == cabx_pkg::word_immediate_difference;
  wire logic [15:0] w_res = w_sub ? word_v - {8'h00, cmd.k} : word_v + {8'h00, cmd.k};
  wire logic        w_v   = w_sub ? (word_v[15] & ~w_res[15]) : (~word_v[15] & w_res[15]);
  wire logic        w_c   = w_sub ? (w_res[15] & ~word_v[15]) : (~w_res[15] & word_v[15]);

  // products: unsigned, signed, signed by unsigned
  wire logic signed [17:0] p_s  = $signed({op_a[7], op_a}) * $signed({op_b[7], op_b});
  wire logic signed [17:0] p_m  = $signed({op_a[7], op_a}) * $signed({1'b0, op_b});
  wire logic [15:0]        p_u  = op_a * op_b;
  // raw product of the offered kind, and whether it is shifted left once
  wire logic        is_s   = (cmd.op == cabx_pkg::product_signed) |
                             (cmd.op == cabx_pkg::scaled_product_signed);
  wire logic        is_m   = (cmd.op == cabx_pkg::product_mixed_sign) |
                             (cmd.op == cabx_pkg::scaled_product_mixed);
  wire logic        scaled = (cmd.op == cabx_pkg::scaled_product_unsigned) |
                             (cmd.op == cabx_pkg::scaled_product_signed) |
                             (cmd.op == cabx_pkg::scaled_product_mixed);
  wire logic [15:0] prod   = is_s ? p_s[15:0] : is_m ? p_m[15:0] : p_u;

  // skip decision for the four skip kinds and compare-equal
  wire logic reg_bit  = op_b[cmd.bsel];
  wire logic skip_hit = (cmd.op == cabx_pkg::compare_skip_equal) & (op_a == op_b) |  // RL15
                        (cmd.op == cabx_pkg::skip_reg_bit_low) & ~reg_bit |          // RL17
                        (cmd.op == cabx_pkg::skip_reg_bit_high) & reg_bit |          // RL17
                        (cmd.op == cabx_pkg::skip_io_bit_low) & ~cmd.io_bit |        // RL18
                        (cmd.op == cabx_pkg::skip_io_bit_high) & cmd.io_bit;         // RL18

  // freshly computed results
  logic [15:0]     f_res;
  logic [7:0]      f_sreg;
  logic [PC_W-1:0] f_pc;
  logic [1:0]      f_wr;          // 1: byte to d, 2: pair d, 3: pair r1:r0
  logic            f_push;
  logic [PC_W-1:0] f_ret;
  logic [2:0]      f_n;

  // result, flags, next pc and cycle count of the offered instruction
  always_comb
  begin
    f_res = '0;
    f_sreg = sreg_reg;            // untouched flags keep their value RL19
    f_pc = pc_one;
    f_wr = 2'h0;
    f_push = 1'b0;
    f_ret = pc_one;
    f_n = `CABX_N1;
    case (cmd.op)
      cabx_pkg::op_sum, cabx_pkg::op_sum_carry:
      begin
        f_res = {8'h00, add_r[7:0]};  // RL1
        f_wr = 2'h1;
        f_sreg[`CABX_FC] = add_r[8];
        f_sreg[`CABX_FV] = add_r[9];
        f_sreg[`CABX_FH] = add_r[10];
        f_sreg[`CABX_FN] = add_r[7];
        f_sreg[`CABX_FZ] = add_r[7:0] == 8'h00;
      end
      cabx_pkg::op_difference, cabx_pkg::register_difference_borrow,
      cabx_pkg::constant_difference, cabx_pkg::constant_difference_borrow,
      cabx_pkg::compare_immediate:
      begin
        f_res = {8'h00, sub_r[7:0]};  // RL2 RL3
        f_wr = cmd.op == cabx_pkg::compare_immediate ? 2'h0 : 2'h1;  // RL16
        f_sreg[`CABX_FC] = sub_r[8];
        f_sreg[`CABX_FV] = sub_r[9];
        f_sreg[`CABX_FH] = sub_r[10];
        f_sreg[`CABX_FN] = sub_r[7];
        // borrowing forms only keep zero set across a chain
        f_sreg[`CABX_FZ] = (sub_r[7:0] == 8'h00) & (brw ? z_in : 1'b1);
      end
      cabx_pkg::word_immediate_sum, cabx_pkg::word_immediate_difference:
      begin
        f_res = w_res;                // RL4
        f_wr = 2'h2;
        f_n = `CABX_N2;
        f_sreg[`CABX_FC] = w_c;
        f_sreg[`CABX_FV] = w_v;
        f_sreg[`CABX_FN] = w_res[15];
        f_sreg[`CABX_FS] = w_res[15] ^ w_v;
        f_sreg[`CABX_FZ] = w_res == 16'h0000;
      end
      cabx_pkg::bitwise_and_constant, cabx_pkg::bitwise_or_constant,
      cabx_pkg::set_bits_mask, cabx_pkg::clear_bits_mask, cabx_pkg::zero_minus_test:
      begin
        case (cmd.op)
          cabx_pkg::bitwise_and_constant: f_res[7:0] = op_a & cmd.k;    // RL5
          cabx_pkg::bitwise_or_constant:  f_res[7:0] = op_a | cmd.k;    // RL5
          cabx_pkg::set_bits_mask:        f_res[7:0] = op_a | cmd.k;    // RL6
          cabx_pkg::clear_bits_mask:      f_res[7:0] = op_a & (`CABX_BYTE_ALL - cmd.k); // RL6
          default:                        f_res[7:0] = op_a & op_a;     // RL7
        endcase
        f_wr = 2'h1;
        f_sreg[`CABX_FV] = 1'b0;
        f_sreg[`CABX_FN] = f_res[7];
        f_sreg[`CABX_FZ] = f_res[7:0] == 8'h00;
      end
      cabx_pkg::product_unsigned, cabx_pkg::product_signed, cabx_pkg::product_mixed_sign,
      cabx_pkg::scaled_product_unsigned, cabx_pkg::scaled_product_signed,
      cabx_pkg::scaled_product_mixed:
      begin
        f_res = scaled ? {prod[14:0], 1'b0} : prod;  // RL8 RL9
        f_wr = 2'h3;
        f_n = `CABX_N2;
        f_sreg[`CABX_FC] = prod[15];
        f_sreg[`CABX_FZ] = f_res == 16'h0000;
      end
      cabx_pkg::pointer_jump:
      begin
        f_pc = PC_W'(z_ptr);          // RL10
        f_n = `CABX_N2;
      end
      cabx_pkg::extended_pointer_jump:
      begin
        f_pc = ez_ptr[PC_W-1:0];      // RL11
        f_n = `CABX_N2;
      end
      cabx_pkg::pointer_call:
      begin
        f_pc = PC_W'(z_ptr);          // RL12
        f_push = 1'b1;
        f_n = `CABX_N4;
      end
      cabx_pkg::extended_pointer_call:
      begin
        f_pc = ez_ptr[PC_W-1:0];      // RL13
        f_push = 1'b1;
        f_n = `CABX_N5;
      end
      cabx_pkg::direct_call:
      begin
        f_pc = cmd.target[PC_W-1:0];  // RL14
        f_ret = pc_two;               // the call itself spans two words
        f_push = 1'b1;
        f_n = `CABX_N5;
      end
      cabx_pkg::compare_skip_equal, cabx_pkg::skip_reg_bit_low,
      cabx_pkg::skip_reg_bit_high, cabx_pkg::skip_io_bit_low,
      cabx_pkg::skip_io_bit_high:
      begin
        if (skip_hit)
        begin
          f_pc = cmd.next_two ? pc_thr : pc_two;      // RL15 RL17 RL18
          f_n = cmd.next_two ? `CABX_N3 : `CABX_N2;
        end
      end
      default: f_n = `CABX_N1;
    endcase
  end

  // commit selection: one-cycle work commits on the taking edge
  wire logic       fin_now  = take & (f_n == `CABX_N1);
  wire logic       fin_late = busy_reg & (cnt_reg == `CABX_N1);
  wire logic       commit   = fin_now | fin_late;
  wire logic [4:0]  c_d     = fin_now ? cmd.d : h_d;
  wire logic [15:0] c_res   = fin_now ? f_res : h_res;
  wire logic [1:0]  c_wr    = fin_now ? f_wr : h_wr;
  wire logic [4:0]  c_dhi   = c_d + 5'h01;
  wire logic       bus_gpr  = ~bus.addr[5];

  // read data mux for the register port
  wire logic [7:0] rd_mux = (bus.addr == `CABX_ADR_SREG) ? sreg_reg :
                            (bus.addr == `CABX_ADR_PAGE) ? page_reg :
                            (bus.addr == `CABX_ADR_PCL)  ? pc_reg[7:0] :
                            (bus.addr == `CABX_ADR_PCM)  ? pc_reg[15:8] :
                            (bus.addr == `CABX_ADR_PCH)  ? 8'(pc_reg[PC_W-1:16]) :
                            bus_gpr ? rf_reg[bus.addr[4:0]] : 8'h00;

  // general registers: execution writes win over the port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
      begin
        rf_reg[i] <= 8'h00;
      end
    end
    else if (commit && c_wr == 2'h1)
      rf_reg[c_d] <= c_res[7:0];
    else if (commit && c_wr == 2'h2)
    begin
      rf_reg[c_d] <= c_res[7:0];
      rf_reg[c_dhi] <= c_res[15:8];
    end
    else if (commit && c_wr == 2'h3)
    begin
      rf_reg[`CABX_R_PLO] <= c_res[7:0];   // RL8
      rf_reg[`CABX_R_PHI] <= c_res[15:8];  // RL8
    end
    else if (bus.wr && bus_gpr)
      rf_reg[bus.addr[4:0]] <= bus.wdata;
  end

  // status, page, pc and port read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sreg_reg <= `CABX_SREG_RST;
      page_reg <= 8'h00;
      pc_reg <= '0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= bus.rd ? rd_mux : 8'h00;
      if (commit)
      begin
        sreg_reg <= fin_now ? f_sreg : h_sreg;  // RL19
        pc_reg <= fin_now ? f_pc : h_pc;
      end
      else if (bus.wr && bus.addr == `CABX_ADR_SREG)
        sreg_reg <= bus.wdata;
      if (bus.wr && bus.addr == `CABX_ADR_PAGE)
        page_reg <= bus.wdata;
    end
  end

  // sequencing of multi-cycle instructions
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 3'h0;
      done_reg <= 1'b0;
      push_reg <= 1'b0;
      push_a_reg <= '0;
      h_d <= 5'h00;
      h_res <= 16'h0000;
      h_sreg <= `CABX_SREG_RST;
      h_pc <= '0;
      h_wr <= 2'h0;
      h_push <= 1'b0;
    end
    else
    begin
      done_reg <= commit;
      push_reg <= commit & (fin_now ? f_push : h_push);
      if (take)
      begin
        busy_reg <= f_n != `CABX_N1;
        cnt_reg <= f_n - `CABX_N1;
        h_d <= cmd.d;
        h_res <= f_res;
        h_sreg <= f_sreg;
        h_pc <= f_pc;
        h_wr <= f_wr;
        h_push <= f_push;
        push_a_reg <= f_ret;
      end
      else if (busy_reg)
      begin
        cnt_reg <= cnt_reg - `CABX_N1;
        busy_reg <= cnt_reg != `CABX_N1;
      end
    end
  end

  assign rdata = rdata_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign pc = pc_reg;
  assign sreg = sreg_reg;
  assign push_valid = push_reg;
  assign push_addr = push_a_reg;
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_one_cycle;
    take && cmd.op == cabx_pkg::op_sum |=> done && !busy;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("add not one cycle"); // RL1
  property p_word_two;
    take && cmd.op == cabx_pkg::word_immediate_sum |=> !done ##1 done;
  endproperty
  a_word_two: assert property (p_word_two) else $error("word add not two cycles"); // RL4
  property p_call_four;
    take && cmd.op == cabx_pkg::pointer_call |=> !done [*3] ##1 (done && push_valid);
  endproperty
  a_call_four: assert property (p_call_four) else $error("pointer call not four"); // RL12
  property p_call_five;
    take && cmd.op == cabx_pkg::direct_call |=> !done [*4] ##1 done;
  endproperty
  a_call_five: assert property (p_call_five) else $error("direct call not five"); // RL14
  property p_jump_z;
    take && cmd.op == cabx_pkg::pointer_jump ##1 !take ##1 done
      |-> pc == PC_W'($past(z_ptr, 2)) && sreg == $past(sreg, 2);
  endproperty
  a_jump_z: assert property (p_jump_z) else $error("pointer jump wrong"); // RL10
  property p_product;
    busy && h_wr == 2'h3 && cnt_reg == 3'h1 |=> {rf_reg[1], rf_reg[0]} == $past(h_res);
  endproperty
  a_product: assert property (p_product) else $error("product not in pair"); // RL8
  property p_logic_v;
    fin_late == 1'b0 && done && $past(take) && $past(cmd.op) == cabx_pkg::bitwise_and_constant
      |-> !sreg[`CABX_FV] && sreg[`CABX_FC] == $past(sreg[`CABX_FC]);
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("and flags wrong"); // RL5
  property p_test_keep;
    take && cmd.op == cabx_pkg::zero_minus_test |=> rf_reg[$past(cmd.d)] == $past(op_a);
  endproperty
  a_test_keep: assert property (p_test_keep) else $error("test changed value"); // RL7
  property p_skip_pc;
    take && skip_hit && cmd.next_two
      |=> !done ##1 !done ##1 (done && pc == $past(pc, 3) + PC_W'(3));
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("two word skip wrong"); // RL15
  property p_cmp_nostore;
    take && cmd.op == cabx_pkg::compare_immediate |=> rf_reg[$past(cmd.d)] == $past(op_a);
  endproperty
  a_cmp_nostore: assert property (p_cmp_nostore) else $error("compare stored"); // RL16

endmodule : cabx_exec

// *** sim/cabx_tb.sv ***
`timescale 1ns/10ps
// one comparison, counted, reported at once on a miss
`define cmp_eq(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  // expected outcome of one instruction
  typedef struct packed {
    logic [21:0] pc;
    logic [7:0]  sr;
    int          n;
    logic        pv;
    logic [21:0] pa;
  } cabx_exp_s;
  logic                clk;
  logic                rst;
  cabx_pkg::cabx_cmd_s cmd;
  cabx_pkg::cabx_bus_s bus;
  logic [7:0]          rdata;
  logic                busy;
  logic                done;
  logic [21:0]         pc;
  logic [7:0]          sreg;
  logic                push_valid;
  logic [21:0]         push_addr;
  logic [7:0]          rf [32];    // model register file
  logic [7:0]          sr;         // model status
  logic [7:0]          pg;         // model jump page register
  logic [21:0]         pcm;        // model program counter
  cabx_exp_s           q_ex [$];   // notes per instruction
  int                  q_tk [$];   // take cycles
  logic [7:0]          q_rd [$];   // notes per read
  int                  cyc;
  logic                rd_d;
  int                  mismatches;
  int                  samples_checked;

  cabx_exec i_cabx_exec (
    .clk        (clk),
    .rst        (rst),
    .cmd        (cmd),
    .bus        (bus),
    .rdata      (rdata),
    .busy       (busy),
    .done       (done),
    .pc         (pc),
    .sreg       (sreg),
    .push_valid (push_valid),
    .push_addr  (push_addr)
  );

  // clock of 40 ns
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // verdict and end of run
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // expected read data of one map address
  function automatic logic [7:0] rv(input logic [5:0] a);
    if (a < 6'h20) return rf[a[4:0]];
    case (a)
      6'h20: return sr;
      6'h21: return pg;
      6'h22: return pcm[7:0];
      6'h23: return pcm[15:8];
      6'h24: return {2'h0, pcm[21:16]};
      default: return 8'h00;   // unmapped reads zero
    endcase
  endfunction : rv

  // one register write, mirrored in the model
  task wr(input logic [5:0] a, input logic [7:0] d);
    if (a < 6'h20) rf[a[4:0]] = d;
    if (a == 6'h20) sr = d;
    if (a == 6'h21) pg = d;
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask : wr

  // one register read, expectation noted
  task rd(input logic [5:0] a);
    q_rd.push_back(rv(a));
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
  endtask : rd

  // one instruction: model it, note it, hold it until its commit edge
  task automatic ex(input cabx_pkg::cabx_cmd_s c);
    cabx_exp_s   e;
    logic [7:0]  a, b, s;
    logic [8:0]  t;
    logic [4:0]  h;
    logic [15:0] w, z, q;
    logic [16:0] u;
    logic [17:0] p;
    logic        ci, sk;
    int          o;
    o = int'(c.op);
    a = rf[c.d];
    b = rf[c.r];
    s = sr;
    z = {rf[31], rf[30]};
    w = {rf[c.d + 5'h1], rf[c.d]};
    e = '{pc: pcm + 22'h1, sr: 8'h00, n: 1, pv: 1'b0, pa: pcm + 22'h1};
    if (o <= 5 || o == 25)
    begin
      // byte sums, differences and compare with constant
      ci = (o == 1 || o == 3 || o == 5) & sr[0];
      if (o >= 4) b = c.k;
      t = (o < 2) ? {1'b0, a} + {1'b0, b} + 9'(ci) : {1'b0, a} - {1'b0, b} - 9'(ci);
      h = (o < 2) ? {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci)
                  : {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(ci);
      s[0] = t[8];
      s[5] = h[4];
      s[2] = t[7];
      s[3] = (a[7] == b[7]) == (o < 2) && t[7] != a[7];
      s[1] = t[7:0] == 8'h00 && ((o != 3 && o != 5) || sr[1]);
      if (o != 25) rf[c.d] = t[7:0];
    end
    else if (o <= 7)
    begin
      // word sum or difference with a constant
      u = (o == 6) ? {1'b0, w} + {9'h000, c.k} : {1'b0, w} - {9'h000, c.k};
      s[0] = u[16];
      s[2] = u[15];
      s[3] = (o == 6) ? !w[15] && u[15] : w[15] && !u[15];
      s[4] = s[2] ^ s[3];
      s[1] = u[15:0] == 16'h0000;
      {rf[c.d + 5'h1], rf[c.d]} = u[15:0];
      e.n = 2;
    end
    else if (o <= 12)
    begin
      // logic with constant, masks and self test
      t[7:0] = (o == 11) ? a & (8'hff - c.k) : (o == 8) ? a & c.k : (o == 12) ? a & a : a | c.k;
      s[1] = t[7:0] == 8'h00;
      s[2] = t[7];
      s[3] = 1'b0;
      rf[c.d] = t[7:0];
    end
    else if (o <= 18)
    begin
      // products into r1:r0, scaled forms shifted once
      p = $signed({(o != 13 && o != 16) & a[7], a}) * $signed({(o == 14 || o == 17) & b[7], b});
      q = (o >= 16) ? {p[14:0], 1'b0} : p[15:0];
      s[0] = p[15];
      s[1] = q == 16'h0000;
      {rf[1], rf[0]} = q;
      e.n = 2;
    end
    else if (o <= 23)
    begin
      // pointer and direct transfers of control
      e.pc = (o == 23) ? c.target : (o == 20 || o == 22) ? {pg[5:0], z} : {6'h00, z};
      e.pv = o >= 21;
      e.pa = (o == 23) ? pcm + 22'h2 : pcm + 22'h1;
      e.n = (o == 21) ? 4 : (o >= 22) ? 5 : 2;
    end
    else
    begin
      // skips, distance set by next instruction length
      sk = (o == 24) ? a == b : (o == 26) ? !b[c.bsel] : (o == 27) ? b[c.bsel]
         : (o == 28) ? !c.io_bit : c.io_bit;
      if (sk) e.n = c.next_two ? 3 : 2;
      e.pc = pcm + 22'(e.n);
    end
    e.sr = s;
    sr = s;
    pcm = e.pc;
    q_ex.push_back(e);
    cmd <= c;
    @(posedge clk);
    repeat (e.n - 1) @(posedge clk);
  endtask : ex

  // read back the whole map, then reload status and page
  task sweep;
    cmd.valid <= 1'b0;
    wr(6'h22, 8'h5a);
    for (int j = 0; j < 37; j++) rd(6'(j));
    rd(6'h3f);
    wr(6'h20, 8'($urandom));
    wr(6'h21, 8'($urandom));
    bus <= '0;
    @(posedge clk);
  endtask : sweep

  // cycle count, read tracking and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rd_d <= bus.rd;
    if (cyc == 6000)
    begin
      mismatches++;
      stop_test;
    end
  end

  // watch outputs and take the oldest note for each result
  always @(negedge clk)
  begin : mon
    cabx_exp_s  e;
    int         tk;
    logic [7:0] rx;
    if (push_valid === 1'b1 && done !== 1'b1) `cmp_eq("push_alone", 1'b0, push_valid)
    if (done === 1'b1 && q_ex.size() > 0)
    begin
      e = q_ex.pop_front();
      tk = q_tk.pop_front();
      `cmp_eq("cycles", e.n, cyc - tk)
      `cmp_eq("busy_at_done", 1'b0, busy)
      `cmp_eq("pc", e.pc, pc)
      `cmp_eq("sreg", e.sr, sreg)
      `cmp_eq("push_valid", e.pv, push_valid)
      if (e.pv) `cmp_eq("push_addr", e.pa, push_addr)
    end
    else if (done === 1'b1) `cmp_eq("done_extra", 1'b0, done)
    if (cmd.valid === 1'b1 && busy === 1'b0) q_tk.push_back(cyc);
    if (rd_d === 1'b1 && q_rd.size() > 0)
    begin
      rx = q_rd.pop_front();
      `cmp_eq("rdata", rx, rdata)
    end
    else if (rdata !== 8'h00) `cmp_eq("rdata_idle", 8'h00, rdata)
  end

  // reset, register fill, then every operation in turn with random operands
  initial
  begin : main
    cabx_pkg::cabx_cmd_s c;
    logic [63:0]         rnd;
    rst = 1'b1;
    cmd = '0;
    bus = '0;
    cyc = 0;
    rd_d = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    sr = 8'h00;
    pg = 8'h00;
    pcm = 22'h0;
    void'($urandom(74));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `cmp_eq("pc_reset", 22'h0, pc)
    `cmp_eq("sreg_reset", 8'h00, sreg)
    @(posedge clk);
    for (int j = 0; j < 32; j++) wr(6'(j), 8'($urandom));
    sweep;
    for (int i = 0; i < 300; i++)
    begin
      rnd = {$urandom, $urandom};
      c = rnd[50:0];
      c.valid = 1'b1;
      c.op = cabx_pkg::cabx_op_e'(5'(i % 30));
      if (i % 30 == 6 || i % 30 == 7) c.d = {2'b11, c.d[2:1], 1'b0};
      if (rnd[63]) c.r = c.d;
      ex(c);
      if (i % 30 == 29) sweep;
    end
    repeat (4) @(posedge clk);
    `cmp_eq("notes_left", 0, q_ex.size())
    stop_test;
  end
endmodule : testbench
